/* File: core/ptm_timer.sv */
// Function
// - mode 00 is compare-match output mode
// - mode 11 compares alike, pin undriven
// - clear-select low: period match clears, both flags
// - clear-select high: match a clears, a flag only
// - match value zero: overflow, no a flag
// - pin changes only on match a flag or run rise
// - run rising edge restores initial pin level
// - pwm: period match clears, clear-select ignored
// - pwm raises a and p flags
// - pwm period value zero means full range
// - duty at or above period: always active
// - pwm keeps running while pin forced
// - initial level picks active level, invert inverts
// - run rising starts pulse, trigger pin sets run
// - pulse ends on clear or match a
// - pulse counter zeroed only on run rise
// - period register width 16 or 10 bits
// - compare pin function: none, low, high, toggle
// - pwm pin function: inactive, active, pwm, pulse
// - initial level bit sets pre-match pin level
`include "ptm_cfg.svh"
`timescale 1ns/1ps
module ptm_timer
	import ptm_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata_q,
	output logic hreadyout_q,
	output logic hresp_q,
	input wire logic external_trigger_pin,
	output logic timer_out_q,
	output logic timer_out_en_q,
	output logic match_a_flag_q,
	output logic match_p_flag_q
);
	// ==========================================
	// declarations
	logic bus_take;
	logic wr_pend_q;
	logic rd_pend_q;
	logic [7:0] wr_addr_q;
	logic [7:0] rd_addr_q;
	logic [31:0] rd_mux;
	logic wr_run;
	logic wr_ctl1;
	logic wr_match_a;
	logic wr_period;
	logic wr_flags;
	logic timer_run_enable_q;
	logic timer_pause_q;
	logic [1:0] trig_sel_q;
	logic [2:0] presc_q;
	ptm_mode_e mode_q;
	logic [1:0] pin_function_q;
	logic initial_level_select_q;
	logic output_invert_q;
	logic clear_source_select_q;
	logic [CNT_W-1:0] match_a_value_q;
	logic [CNT_W-1:0] period_value_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_nxt;
	logic [6:0] pre_cnt_q;
	logic run_prev_q;
	logic trig_s1_q;
	logic trig_s2_q;
	logic trig_s3_q;
	logic pin_q;
	logic sp_mode;
	logic pwm_mode;
	logic cm_mode;
	logic run_rise;
	logic tick;
	logic a_hit;
	logic p_hit;
	logic cnt_clr;
	logic trig_edge;
	logic trig_set;
	logic pwm_active;
	logic act_lvl;

	// ==========================================
	// helpers
	function automatic logic [6:0] presc_mask(input logic [2:0] sel);
		presc_mask = 7'h7f >> (3'h7 - sel);
	endfunction

	function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[CNT_W-1:0] = v;
		widen = w;
	endfunction

	// ==========================================
	// bus address phase
	assign bus_take = hsel & hready & htrans[1];

	// reads get one wait state so a preceding write is always visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rd_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= bus_take & hwrite;
			rd_pend_q <= bus_take & ~hwrite;
			if (bus_take) begin
				wr_addr_q <= haddr[7:0];
				rd_addr_q <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			hrdata_q <= 32'h0000_0000;
		end else begin
			hresp_q <= 1'b0;
			hreadyout_q <= ~(bus_take & ~hwrite);
			if (rd_pend_q) begin
				hrdata_q <= rd_mux;
			end
		end
	end

	// ==========================================
	// read mux, unmapped reads as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (rd_addr_q)
			`PTM_OFS_RUN: begin
				rd_mux[`PTM_RUN_BIT] = timer_run_enable_q;
				rd_mux[`PTM_PAUSE_BIT] = timer_pause_q;
				rd_mux[`PTM_TRIG_LO +: 2] = trig_sel_q;
				rd_mux[`PTM_PRESC_LO +: 3] = presc_q;
			end
			`PTM_OFS_CTL1: begin
				rd_mux[`PTM_MODE_LO +: 2] = mode_q;
				rd_mux[`PTM_PINF_LO +: 2] = pin_function_q;
				rd_mux[`PTM_INIT_BIT] = initial_level_select_q;
				rd_mux[`PTM_INV_BIT] = output_invert_q;
				rd_mux[`PTM_CCLR_BIT] = clear_source_select_q;
			end
			`PTM_OFS_MATCH_A: begin
				rd_mux = widen(match_a_value_q);
			end
			`PTM_OFS_PERIOD: begin
				rd_mux = widen(period_value_q);
			end
			`PTM_OFS_COUNT: begin
				rd_mux = widen(cnt_q);
			end
			`PTM_OFS_FLAGS: begin
				rd_mux[`PTM_FLAG_A_BIT] = match_a_flag_q;
				rd_mux[`PTM_FLAG_P_BIT] = match_p_flag_q;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// ==========================================
	// write strobes
	assign wr_run = wr_pend_q & (wr_addr_q == `PTM_OFS_RUN);
	assign wr_ctl1 = wr_pend_q & (wr_addr_q == `PTM_OFS_CTL1);
	assign wr_match_a = wr_pend_q & (wr_addr_q == `PTM_OFS_MATCH_A);
	assign wr_period = wr_pend_q & (wr_addr_q == `PTM_OFS_PERIOD);
	assign wr_flags = wr_pend_q & (wr_addr_q == `PTM_OFS_FLAGS);

	// ==========================================
	// control registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= PTM_MODE_CMP;
			pin_function_q <= 2'h0;
			initial_level_select_q <= 1'b0;
			output_invert_q <= 1'b0;
			clear_source_select_q <= 1'b0;
		end else if (wr_ctl1) begin
			mode_q <= ptm_mode_e'(hwdata[`PTM_MODE_LO +: 2]);
			pin_function_q <= hwdata[`PTM_PINF_LO +: 2];
			initial_level_select_q <= hwdata[`PTM_INIT_BIT];
			output_invert_q <= hwdata[`PTM_INV_BIT];
			clear_source_select_q <= hwdata[`PTM_CCLR_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_pause_q <= 1'b0;
			trig_sel_q <= 2'h0;
			presc_q <= 3'h0;
		end else if (wr_run) begin
			timer_pause_q <= hwdata[`PTM_PAUSE_BIT];
			trig_sel_q <= hwdata[`PTM_TRIG_LO +: 2];
			presc_q <= hwdata[`PTM_PRESC_LO +: 3];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			match_a_value_q <= CNT_W'(`PTM_CMP_RST);
			period_value_q <= CNT_W'(`PTM_CMP_RST);
		end else begin
			if (wr_match_a) begin
				match_a_value_q <= hwdata[CNT_W-1:0];
			end
			if (wr_period) begin
				period_value_q <= hwdata[CNT_W-1:0];
			end
		end
	end

	// ==========================================
	// mode decode
	// pwm selected by mode and pins
	// pulse selected by mode and pins
	assign sp_mode = (mode_q == PTM_MODE_PWM) & (pin_function_q == PTM_PF_11);
	assign pwm_mode = (mode_q == PTM_MODE_PWM) & ~sp_mode;
	assign cm_mode = (mode_q == PTM_MODE_CMP) | (mode_q == PTM_MODE_TMR);

	// ==========================================
	// trigger pin synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trig_s1_q <= 1'b0;
			trig_s2_q <= 1'b0;
			trig_s3_q <= 1'b0;
		end else begin
			trig_s1_q <= external_trigger_pin;
			trig_s2_q <= trig_s1_q;
			trig_s3_q <= trig_s2_q;
		end
	end

	// trig_sel: bit 0 rising, bit 1 falling
	assign trig_edge = (trig_sel_q[0] & trig_s2_q & ~trig_s3_q)
		| (trig_sel_q[1] & ~trig_s2_q & trig_s3_q);
	assign trig_set = trig_edge & sp_mode & ~timer_run_enable_q;

	// ==========================================
	// tick and compare
	assign run_rise = timer_run_enable_q & ~run_prev_q;
	assign tick = timer_run_enable_q & ~timer_pause_q & ~run_rise
		& ((pre_cnt_q & presc_mask(presc_q)) == presc_mask(presc_q));
	assign cnt_nxt = cnt_q + 1'b1;
	assign a_hit = tick & (cnt_nxt == match_a_value_q) & (|match_a_value_q)
		& (mode_q != PTM_MODE_UNDEF);
	// no period flag with clear-select high, except in pwm
	assign p_hit = tick & (cnt_nxt == period_value_q)
		& (pwm_mode | (cm_mode & ~clear_source_select_q));
	assign cnt_clr = p_hit | (a_hit & cm_mode & clear_source_select_q);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_cnt_q <= 7'h00;
		end else if (run_rise) begin
			pre_cnt_q <= 7'h00;
		end else if (timer_run_enable_q & ~timer_pause_q) begin
			pre_cnt_q <= pre_cnt_q + 7'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_prev_q <= 1'b0;
		end else begin
			run_prev_q <= timer_run_enable_q;
		end
	end

	// zeroed only on run rise in pulse mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
		end else if (run_rise) begin
			cnt_q <= '0;
		end else if (tick) begin
			if (cnt_clr & ~sp_mode) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_nxt;
			end
		end
	end

	// ==========================================
	// run enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_run_enable_q <= 1'b0;
		end else begin
			if (wr_run) begin
				timer_run_enable_q <= hwdata[`PTM_RUN_BIT];
			end else if (sp_mode & a_hit) begin
				timer_run_enable_q <= 1'b0;
			end
			if (trig_set) begin
				timer_run_enable_q <= 1'b1;
			end
		end
	end

	// ==========================================
	// match flags, a set beats a clear
	// pwm raises both flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			match_a_flag_q <= 1'b0;
			match_p_flag_q <= 1'b0;
		end else begin
			match_a_flag_q <= a_hit
				| (match_a_flag_q & ~(wr_flags & hwdata[`PTM_FLAG_A_BIT]));
			match_p_flag_q <= p_hit
				| (match_p_flag_q & ~(wr_flags & hwdata[`PTM_FLAG_P_BIT]));
		end
	end

	// ==========================================
	// compare-mode pin state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_q <= 1'b0;
		end else if (run_rise) begin
			pin_q <= initial_level_select_q;
		end else if (a_hit & cm_mode) begin
			case (pin_function_q)
				PTM_PF_01: pin_q <= 1'b0;
				PTM_PF_10: pin_q <= 1'b1;
				PTM_PF_11: pin_q <= ~pin_q;
				default: pin_q <= pin_q;
			endcase
		end
	end

	// ==========================================
	// pwm waveform and pin driver
	// duty at or above period is full
	assign pwm_active = ((|period_value_q) & (match_a_value_q >= period_value_q))
		| (cnt_q < match_a_value_q);
	assign act_lvl = initial_level_select_q ^ output_invert_q;

	// pwm counting runs regardless of pin forcing, so unforcing is glitch free
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_out_q <= 1'b0;
			timer_out_en_q <= 1'b0;
		end else begin
			case (mode_q)
				PTM_MODE_CMP: begin
					timer_out_en_q <= 1'b1;
					timer_out_q <= pin_q ^ output_invert_q;
				end
				PTM_MODE_PWM: begin
					timer_out_en_q <= 1'b1;
					case (pin_function_q)
						PTM_PF_00: timer_out_q <= ~act_lvl;
						PTM_PF_01: timer_out_q <= act_lvl;
						PTM_PF_10: timer_out_q <= pwm_active ? act_lvl : ~act_lvl;
						default: timer_out_q <= timer_run_enable_q ? act_lvl : ~act_lvl;
					endcase
				end
				default: begin
					timer_out_en_q <= 1'b0;
					timer_out_q <= 1'b0;
				end
			endcase
		end
	end

	// hsize and upper address bits are not decoded; only word access is supported
endmodule // ptm_timer

/* File: core/ptm_cfg.svh */
`ifndef PTM_CFG_SVH
`define PTM_CFG_SVH
// ==========================================
// register offsets (byte addresses)
`define PTM_OFS_RUN 8'h00
`define PTM_OFS_CTL1 8'h04
`define PTM_OFS_MATCH_A 8'h08
`define PTM_OFS_PERIOD 8'h0c
`define PTM_OFS_COUNT 8'h10
`define PTM_OFS_FLAGS 8'h14
// ==========================================
// run register fields
`define PTM_RUN_BIT 0
`define PTM_PAUSE_BIT 1
`define PTM_TRIG_LO 2
`define PTM_PRESC_LO 4
// ==========================================
// timer_control_one fields
`define PTM_MODE_LO 6
`define PTM_PINF_LO 4
`define PTM_INIT_BIT 3
`define PTM_INV_BIT 2
`define PTM_CCLR_BIT 0
// ==========================================
// flag register fields
`define PTM_FLAG_A_BIT 0
`define PTM_FLAG_P_BIT 1
// ==========================================
// reset values
`define PTM_CTL1_RST 8'h00
`define PTM_RUN_RST 8'h00
`define PTM_CMP_RST 16'h0000
`endif

/* File: core/ptm_pkg.sv */
package ptm_pkg;
	// ==========================================
	// operating modes
	typedef enum logic [1:0] {
		PTM_MODE_CMP = 2'h0,
		PTM_MODE_UNDEF = 2'h1,
		PTM_MODE_PWM = 2'h2,
		PTM_MODE_TMR = 2'h3
	} ptm_mode_e;
	// ==========================================
	// pin function codes
	typedef enum logic [1:0] {
		PTM_PF_00 = 2'h0,
		PTM_PF_01 = 2'h1,
		PTM_PF_10 = 2'h2,
		PTM_PF_11 = 2'h3
	} ptm_pinf_e;
endpackage

/* File: test/ptm_checker.sv */
`timescale 1ns/1ps
`include "ptm_cfg.svh"
module ptm_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic hreadyout_q,
	input wire logic hresp_q,
	input wire logic timer_out_q,
	input wire logic timer_out_en_q,
	input wire logic match_a_flag_q,
	input wire logic match_p_flag_q
);
	// ==========================================
	// shadow of writes; run only follows software, so hardware starts are not seen
	logic ap_wr_q, run_q;
	logic [7:0] ap_adr_q, ctl_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_q <= 1'h0;
			ap_adr_q <= 8'h00;
		end else if (hready) begin
			ap_wr_q <= hsel && htrans[1] && hwrite;
			ap_adr_q <= haddr[7:0];
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_q <= 8'h00;
			run_q <= 1'h0;
		end else if (ap_wr_q && ap_adr_q == `PTM_OFS_CTL1) begin
			ctl_q <= hwdata[7:0];
		end else if (ap_wr_q && ap_adr_q == `PTM_OFS_RUN) begin
			run_q <= hwdata[0];
		end
	end
	// ==========================================
	// properties
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (!hresp_q) else $error("error response");
	a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout_q ##1 hreadyout_q)
		else $error("read wait state wrong");
	a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout_q)
		else $error("write stalled");
	a_flag_clear_cause: assert property ($fell(match_a_flag_q) || $fell(match_p_flag_q)
		|-> $past(ap_wr_q && ap_adr_q == `PTM_OFS_FLAGS)) else $error("flag dropped on its own");
	a_pin_enable: assert property ($past(hresetn) && $stable(ctl_q) |-> timer_out_en_q == !ctl_q[6])
		else $error("pin enable wrong");
	a_no_pflag: assert property (ctl_q[7] == ctl_q[6] && ctl_q[0] && $stable(ctl_q) && !$past(match_p_flag_q)
		|-> !match_p_flag_q) else $error("p flag with clear on a");
	a_run_restore: assert property (ctl_q[7:6] == 2'h0 && $rose(run_q)
		|-> ##[1:2] timer_out_q == (ctl_q[3] ^ ctl_q[2])) else $error("pin not restored");
	a_pwm_force: assert property (ctl_q[7:6] == 2'h2 && !ctl_q[5] && !ctl_q[2] && run_q && $past(run_q, 2)
		&& ctl_q == $past(ctl_q) && ctl_q == $past(ctl_q, 2) |-> timer_out_q == (ctl_q[3] ~^ ctl_q[4]))
		else $error("forced level wrong");
endmodule // ptm_checker
bind ptm_timer ptm_checker chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q),
	.timer_out_q(timer_out_q), .timer_out_en_q(timer_out_en_q), .match_a_flag_q(match_a_flag_q),
	.match_p_flag_q(match_p_flag_q));

/* File: test/ptm_pin_partner.sv */
`timescale 1ns/1ps
module ptm_pin_partner #(
	parameter int DLY = 2
) (
	input wire logic hclk,
	input wire logic trig_cmd,
	input wire logic timer_out_q,
	input wire logic timer_out_en_q,
	output logic trig_pin,
	output wire logic pin
);
	logic [7:0] dly_q = 8'h00;
	always @(posedge hclk) dly_q <= {dly_q[6:0], trig_cmd};
	assign trig_pin = dly_q[DLY];
	// a pull-up holds the pin once the timer lets go of it
	assign pin = timer_out_en_q ? timer_out_q : 1'h1;
endmodule // ptm_pin_partner

/* File: test/periodic_timer_module_tb.sv */
`timescale 1ns/1ps
`include "ptm_cfg.svh"
module periodic_timer_module_tb;
	localparam int W = 10;
	logic hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0, trig_cmd = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, seed = 32'h7b5a;
	logic [7:0] cset [3] = '{8'ha8, 8'ha0, 8'hac};
	wire logic [31:0] hrdata_q;
	wire logic hreadyout_q, hresp_q, timer_out_q, timer_out_en_q, match_a_flag_q, match_p_flag_q, trig_pin, pin;
	int miscompares = 0, samples_checked = 0, cyc = 0, hi, lo, p, a;
	always #25 hclk = ~hclk;
	ptm_timer #(.CNT_W(W)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(hreadyout_q), .hwdata(hwdata), .hrdata_q(hrdata_q),
		.hreadyout_q(hreadyout_q), .hresp_q(hresp_q), .external_trigger_pin(trig_pin), .timer_out_q(timer_out_q),
		.timer_out_en_q(timer_out_en_q), .match_a_flag_q(match_a_flag_q), .match_p_flag_q(match_p_flag_q));
	ptm_pin_partner #(.DLY(3)) pp (.hclk(hclk), .trig_cmd(trig_cmd), .timer_out_q(timer_out_q),
		.timer_out_en_q(timer_out_en_q), .trig_pin(trig_pin), .pin(pin));
	// ==========================================
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int per(int p0);
		return (p0 == 0) ? (1 << W) : p0;
	endfunction
	function automatic int exp_hi(logic [7:0] c, int a0, int p0);
		return (c[3] ^ c[2]) ? a0 : per(p0) - a0;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
		haddr <= {24'h00_0000, ad};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout_q !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout_q !== 1'h1);
		r = hrdata_q;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	task automatic cfg(input logic [7:0] c, input int a0, input int p0);
		xfer(1'h1, `PTM_OFS_RUN, 32'h0);
		xfer(1'h1, `PTM_OFS_CTL1, {24'h00_0000, c});
		xfer(1'h1, `PTM_OFS_MATCH_A, 32'(a0));
		xfer(1'h1, `PTM_OFS_PERIOD, 32'(p0));
		xfer(1'h1, `PTM_OFS_FLAGS, 32'h3);
		xfer(1'h1, `PTM_OFS_RUN, 32'h1);
	endtask
	task automatic rdf();
		xfer(1'h0, `PTM_OFS_FLAGS, 32'h0);
	endtask
	// full high phase, then full low phase, of the pin
	task automatic meas();
		@(posedge pin);
		hi = 0;
		lo = 0;
		do begin @(posedge hclk); #1; hi++; end while (pin === 1'h1);
		do begin @(posedge hclk); #1; lo++; end while (pin === 1'h0);
	endtask
	task automatic pwm(input logic [7:0] c, input int a0, input int p0);
		cfg(c, a0, p0);
		meas();
		meas();
		chk("pwm high", 32'(exp_hi(c, a0, p0)), 32'(hi));
		chk("pwm period", 32'(per(p0)), 32'(hi + lo));
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 80000) begin
			miscompares++;
			end_sim();
		end
	end
	// ==========================================
	// sequence
	initial begin
		wt(20);
		hresetn <= 1'h1;
		wt(1);
		for (int i = 0; i < 7; i++) begin
			xfer(1'h0, 8'(i * 4), 32'h0);
			chk("reset value", 32'h0, r);
		end
		xfer(1'h1, 8'h18, 32'hffff_ffff);
		xfer(1'h0, 8'h18, 32'h0);
		chk("unmapped", 32'h0, r);
		for (int i = 0; i < 3; i++) begin
			xfer(1'h1, `PTM_OFS_PERIOD, rnd());
			xfer(1'h0, `PTM_OFS_PERIOD, 32'h0);
			chk("period width", seed & 32'h0000_03ff, r);
		end
		$display("register test done");
		// first high phase after a run start is the restore level, so skip it
		cfg(8'h38, 3, 8);
		meas();
		meas();
		chk("toggle high", 32'h8, 32'(hi));
		rdf();
		chk("both flags", 32'h3, r);
		cfg(8'h39, 6, 3);
		meas();
		meas();
		chk("clear on a", 32'h6, 32'(hi));
		rdf();
		chk("a flag only", 32'h1, r);
		cfg(8'hf9, 6, 3);
		wt(20);
		chk("pin released", 32'h0, {31'h0, timer_out_en_q});
		rdf();
		chk("timer flags", 32'h1, r);
		// zero match value only in timer mode, compare mode forbids it
		cfg(8'hf9, 0, 3);
		wt(1100);
		chk("no a match pin", 32'h1, {31'h0, pin});
		rdf();
		chk("zero match", 32'h0, r);
		for (int f = 0; f < 3; f++) begin
			cfg({2'h0, 2'(f), 1'(f != 2), 3'h0}, 2, 5);
			wt(30);
			chk("pin function", {31'h0, 1'(f != 1)}, {31'h0, pin});
		end
		$display("compare test done");
		pwm(8'ha8, 100, 0);
		for (int i = 0; i < 6; i++) begin
			p = 4 + int'(rnd() % 40);
			a = 1 + int'(rnd() % (p - 1));
			pwm(cset[i % 3], a, p);
		end
		cfg(8'ha8, 9, 9);
		wt(4);
		for (int i = 0; i < 20; i++) begin
			wt(1);
			chk("full duty", 32'h1, {31'h0, pin});
		end
		cfg(8'h88, 3, 6);
		wt(20);
		chk("forced low", 32'h0, {31'h0, pin});
		rdf();
		chk("pwm flags", 32'h3, r);
		cfg(8'h98, 3, 6);
		wt(20);
		chk("forced high", 32'h1, {31'h0, pin});
		$display("pwm test done");
		cfg(8'hb8, 5, 2);
		wt(3);
		chk("pulse lead", 32'h1, {31'h0, pin});
		wt(20);
		xfer(1'h0, `PTM_OFS_RUN, 32'h0);
		chk("run self clear", 32'h0, r & 32'h1);
		chk("pulse trail", 32'h0, {31'h0, pin});
		rdf();
		chk("pulse flags", 32'h1, r);
		xfer(1'h1, `PTM_OFS_FLAGS, 32'h3);
		xfer(1'h1, `PTM_OFS_RUN, 32'h4);
		trig_cmd <= 1'h1;
		wt(30);
		rdf();
		chk("trigger pulse", 32'h1, r);
		trig_cmd <= 1'h0;
		cfg(8'hb8, 200, 2);
		wt(5);
		xfer(1'h1, `PTM_OFS_RUN, 32'h0);
		wt(3);
		chk("software trail", 32'h0, {31'h0, pin});
		rdf();
		chk("no early match", 32'h0, r);
		$display("pulse test done");
		end_sim();
	end
endmodule // periodic_timer_module_tb
